// *** design/gpcn_pkg.sv ***
/*
 * Shared constants of the general purpose port with change notification:
 * register indices, alias codes, field positions and reset values.
 * Assumes a 32-bit APB with byte address = index * 16 + alias * 4.
 */
`default_nettype none
package gpcn_pkg;

    localparam int NPIN = 16;
    localparam int AW   = 8;

    // Register index sits in address bits 7:4, alias code in bits 3:2.
    localparam int IDX_LSB   = 4;
    localparam int ALIAS_LSB = 2;

    localparam logic [3:0] IDX_ANALOG = 4'h0;
    localparam logic [3:0] IDX_DIR    = 4'h1;
    localparam logic [3:0] IDX_PIN    = 4'h2;
    localparam logic [3:0] IDX_LAT    = 4'h3;
    localparam logic [3:0] IDX_ODC    = 4'h4;
    localparam logic [3:0] IDX_PU     = 4'h5;
    localparam logic [3:0] IDX_PD     = 4'h6;
    localparam logic [3:0] IDX_CTRL   = 4'h7;
    localparam logic [3:0] IDX_CNEN   = 4'h8;
    localparam logic [3:0] IDX_FLAGS  = 4'h9;
    localparam logic [3:0] IDX_LAST   = IDX_FLAGS;

    typedef enum logic [1:0]
    {
        GPCN_WR_BASE = 2'b00,
        GPCN_WR_CLR  = 2'b01,
        GPCN_WR_SET  = 2'b10,
        GPCN_WR_INV  = 2'b11
    } gpcn_wr_t;

    // Change notification on/off bit of the control register.
    localparam int CTRL_ON_BIT = 15;

    localparam logic [NPIN-1:0] RST_ANALOG = 16'hFFFF;
    localparam logic [NPIN-1:0] RST_DIR    = 16'hFFFF;
    localparam logic [NPIN-1:0] RST_ZERO   = 16'h0000;
    localparam logic            RST_CN_ON  = 1'b0;

endpackage
`default_nettype wire

// *** design/gpcn_cn_if.sv ***
/*
 * Bundle between the port core and its change detector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gpcn_cn_if;
    import gpcn_pkg::*;

    logic [NPIN-1:0] level;
    logic [NPIN-1:0] enable;
    logic [NPIN-1:0] clear;
    logic            active;
    logic [NPIN-1:0] flags;
    logic            irq;

    modport port
    (
        output level,
        output enable,
        output clear,
        output active,
        input  flags,
        input  irq
    );

    modport det
    (
        input  level,
        input  enable,
        input  clear,
        input  active,
        output flags,
        output irq
    );
endinterface
`default_nettype wire

// *** design/gpcn_change_det.sv ***
/*
 * Per-pin change detector: sticky change flags and the change request.
 * Assumes level comes from flip-flops on the same clock as this module.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcn_change_det
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    gpcn_cn_if.det    cn
);
    import gpcn_pkg::*;

    logic [NPIN-1:0] prev_r;
    logic [NPIN-1:0] flags_r;
    logic [NPIN-1:0] flags_nxt;
    logic            irq_r;
    logic [NPIN-1:0] set_w;

    assign set_w     = (cn.level ^ prev_r) & cn.enable & {NPIN{cn.active}};
    // A change in the clearing cycle survives the clear.
    assign flags_nxt = (flags_r & ~cn.clear) | set_w;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prev_r  <= RST_ZERO;
            flags_r <= RST_ZERO;
            irq_r   <= 1'b0;
        end
        else
        begin
            prev_r  <= cn.level;
            flags_r <= flags_nxt;
            irq_r   <= |(flags_r & cn.enable);
        end
    end

    assign cn.flags = flags_r;
    assign cn.irq   = irq_r;

    a_flag_on_change: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (|set_w) |=> ((flags_r & $past(set_w)) == $past(set_w)))
        else $error("change flag not set after a pin change");

    a_change_raises_irq: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (|set_w) ##1 (cn.clear == '0) |-> ##1 irq_r)
        else $error("enabled pin change did not raise the request");

    a_irq_needs_flag: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ((flags_r & cn.enable) == '0) |=> !irq_r)
        else $error("request raised without an enabled flag");
endmodule
`default_nettype wire

// *** design/gpcn_port.sv ***
/*
 * General purpose 16-pin port with APB registers, open drain, pulls,
 * analog select, alternate function override and change notification.
 * Assumes a single APB master on CLK_I, pads resolving PIN_O/PIN_OE_O,
 * and a power controller that holds SLEEP_I high while clocks stop.
 */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module gpcn_port
    import gpcn_pkg::*;
(
    // Clock and reset.
    input  wire logic                     CLK_I,
    input  wire logic                     RSTN_I,
    // APB slave.
    input  wire logic                     PSEL_I,
    input  wire logic                     PENABLE_I,
    input  wire logic                     PWRITE_I,
    input  wire logic [gpcn_pkg::AW-1:0]  PADDR_I,
    input  wire logic [31:0]              PWDATA_I,
    input  wire logic [3:0]               PSTRB_I,
    output logic      [31:0]              PRDATA_O,
    output logic                          PREADY_O,
    output logic                          PSLVERR_O,
    // Pads.
    input  wire logic [gpcn_pkg::NPIN-1:0] PIN_I,
    output logic      [gpcn_pkg::NPIN-1:0] PIN_O,
    output logic      [gpcn_pkg::NPIN-1:0] PIN_OE_O,
    output logic      [gpcn_pkg::NPIN-1:0] PULLUP_O,
    output logic      [gpcn_pkg::NPIN-1:0] PULLDN_O,
    output logic      [gpcn_pkg::NPIN-1:0] ANALOG_O,
    // Alternate peripheral functions.
    input  wire logic [gpcn_pkg::NPIN-1:0] ALT_EN_I,
    input  wire logic [gpcn_pkg::NPIN-1:0] ALT_OUT_I,
    input  wire logic [gpcn_pkg::NPIN-1:0] ALT_OE_I,
    output logic      [gpcn_pkg::NPIN-1:0] PIN_IN_O,
    // Power and events.
    input  wire logic                     SLEEP_I,
    output logic                          WAKE_O,
    output logic                          IRQ_O
);
    import gpcn_pkg::*;

    logic [NPIN-1:0] ansel_r;
    logic [NPIN-1:0] dir_r;
    logic [NPIN-1:0] lat_r;
    logic [NPIN-1:0] odc_r;
    logic [NPIN-1:0] pu_r;
    logic [NPIN-1:0] pd_r;
    logic [NPIN-1:0] cnen_r;
    logic            cn_on_r;
    logic [NPIN-1:0] ansel_nxt;
    logic [NPIN-1:0] dir_nxt;
    logic [NPIN-1:0] lat_nxt;
    logic [NPIN-1:0] odc_nxt;
    logic [NPIN-1:0] pu_nxt;
    logic [NPIN-1:0] pd_nxt;
    logic [NPIN-1:0] cnen_nxt;
    logic            cn_on_nxt;
    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [NPIN-1:0] pin_o_r;
    logic [NPIN-1:0] pin_oe_r;
    logic [NPIN-1:0] pin_o_nxt;
    logic [NPIN-1:0] pin_oe_nxt;
    logic [NPIN-1:0] clr_snap_r;
    logic [NPIN-1:0] clr_snap_nxt;
    logic [31:0]     prdata_r;
    logic [31:0]     prdata_nxt;
    logic            pready_r;
    logic            pslverr_r;
    logic            wake_r;

    gpcn_cn_if cn ();

    gpcn_change_det u_det
    (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .cn     (cn)
    );

    // Bus decode.
    wire [3:0]      reg_idx  = PADDR_I[IDX_LSB +: 4];
    wire gpcn_wr_t  wr_kind  = gpcn_wr_t'(PADDR_I[ALIAS_LSB +: 2]);
    wire            mapped   = (reg_idx <= IDX_LAST) &&
                               (PADDR_I[1:0] == 2'b00);
    wire            setup    = PSEL_I && !PENABLE_I;
    wire            acc      = PSEL_I && PENABLE_I && pready_r;
    wire            wr_ok    = acc && PWRITE_I && !pslverr_r;
    wire            rd_ok    = acc && !PWRITE_I && !pslverr_r;
    wire [NPIN-1:0] lane_m   = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
    wire [NPIN-1:0] wdat     = PWDATA_I[NPIN-1:0];
    wire            is_base  = (wr_kind == GPCN_WR_BASE);
    wire            pin_read = rd_ok && is_base && (reg_idx == IDX_PIN);

    // Pin view: analog inputs read as low.
    wire [NPIN-1:0] ana_in   = ansel_r & dir_r;
    wire [NPIN-1:0] pin_view = pin_s2_r & ~ana_in;

    function automatic logic [NPIN-1:0] upd
    (
        input logic [NPIN-1:0] old,
        input logic [NPIN-1:0] wd,
        input logic [NPIN-1:0] m,
        input gpcn_wr_t        kind
    );
        logic [NPIN-1:0] b;
        b = wd & m;
        case (kind)
            GPCN_WR_CLR: upd = old & ~b;
            GPCN_WR_SET: upd = old | b;
            GPCN_WR_INV: upd = old ^ b;
            default:     upd = (old & ~m) | b;
        endcase
    endfunction

    function automatic logic hit
    (
        input logic       ok,
        input logic [3:0] idx,
        input logic [3:0] want
    );
        hit = ok && (idx == want);
    endfunction

    // Register updates; the pin register writes land in the latch.
    assign ansel_nxt = hit(wr_ok, reg_idx, IDX_ANALOG) ?
                       upd(ansel_r, wdat, lane_m, wr_kind) : ansel_r;
    assign dir_nxt   = hit(wr_ok, reg_idx, IDX_DIR) ?
                       upd(dir_r, wdat, lane_m, wr_kind) : dir_r;
    assign lat_nxt   = (hit(wr_ok, reg_idx, IDX_LAT) ||
                        hit(wr_ok, reg_idx, IDX_PIN)) ?
                       upd(lat_r, wdat, lane_m, wr_kind) : lat_r;
    assign odc_nxt   = hit(wr_ok, reg_idx, IDX_ODC) ?
                       upd(odc_r, wdat, lane_m, wr_kind) : odc_r;
    assign pu_nxt    = hit(wr_ok, reg_idx, IDX_PU) ?
                       upd(pu_r, wdat, lane_m, wr_kind) : pu_r;
    assign pd_nxt    = hit(wr_ok, reg_idx, IDX_PD) ?
                       upd(pd_r, wdat, lane_m, wr_kind) : pd_r;
    assign cnen_nxt  = hit(wr_ok, reg_idx, IDX_CNEN) ?
                       upd(cnen_r, wdat, lane_m, wr_kind) : cnen_r;
    wire [NPIN-1:0] ctrl_upd = upd({cn_on_r, 15'h0000}, wdat, lane_m,
                                   wr_kind);
    assign cn_on_nxt = hit(wr_ok, reg_idx, IDX_CTRL) ?
                       ctrl_upd[CTRL_ON_BIT] : cn_on_r;

    // Read mux; alias addresses read as zero.
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (setup && !PWRITE_I)
        begin
            prdata_nxt = 32'h0000_0000;
            if (mapped && (wr_kind == GPCN_WR_BASE))
            begin
                case (reg_idx)
                    IDX_ANALOG: prdata_nxt[NPIN-1:0] = ansel_r;
                    IDX_DIR:    prdata_nxt[NPIN-1:0] = dir_r;
                    IDX_PIN:    prdata_nxt[NPIN-1:0] = pin_view;
                    IDX_LAT:    prdata_nxt[NPIN-1:0] = lat_r;
                    IDX_ODC:    prdata_nxt[NPIN-1:0] = odc_r;
                    IDX_PU:     prdata_nxt[NPIN-1:0] = pu_r;
                    IDX_PD:     prdata_nxt[NPIN-1:0] = pd_r;
                    IDX_CTRL:   prdata_nxt[CTRL_ON_BIT] = cn_on_r;
                    IDX_CNEN:   prdata_nxt[NPIN-1:0] = cnen_r;
                    IDX_FLAGS:  prdata_nxt[NPIN-1:0] = cn.flags;
                    default:    prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Only flags visible when the pins were sampled are cleared, so a
    // change between setup and access is kept for the next read.
    assign clr_snap_nxt = setup ? cn.flags : clr_snap_r;
    assign cn.clear     = pin_read ? clr_snap_r : RST_ZERO;
    assign cn.level     = pin_view;
    assign cn.enable    = cnen_r;
    assign cn.active    = cn_on_r;

    // Pad drive: alternate function first, else port logic.
    wire [NPIN-1:0] gp_oe = ~dir_r & (~odc_r | ~lat_r);
    wire [NPIN-1:0] gp_o  = lat_r & ~odc_r;
    assign pin_oe_nxt = (ALT_EN_I & ALT_OE_I) | (~ALT_EN_I & gp_oe);
    assign pin_o_nxt  = (ALT_EN_I & ALT_OUT_I) | (~ALT_EN_I & gp_o);

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ansel_r    <= RST_ANALOG;
            dir_r      <= RST_DIR;
            lat_r      <= RST_ZERO;
            odc_r      <= RST_ZERO;
            pu_r       <= RST_ZERO;
            pd_r       <= RST_ZERO;
            cnen_r     <= RST_ZERO;
            cn_on_r    <= RST_CN_ON;
            pin_o_r    <= RST_ZERO;
            pin_oe_r   <= RST_ZERO;
            clr_snap_r <= RST_ZERO;
        end
        else
        begin
            ansel_r    <= ansel_nxt;
            dir_r      <= dir_nxt;
            lat_r      <= lat_nxt;
            odc_r      <= odc_nxt;
            pu_r       <= pu_nxt;
            pd_r       <= pd_nxt;
            cnen_r     <= cnen_nxt;
            cn_on_r    <= cn_on_nxt;
            pin_o_r    <= pin_o_nxt;
            pin_oe_r   <= pin_oe_nxt;
            clr_snap_r <= clr_snap_nxt;
        end
    end

    // Bus answer: one wait-free access cycle after each setup cycle.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r  <= prdata_nxt;
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
        end
    end

    // Pin synchroniser; only the second stage is read.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pin_s1_r <= RST_ZERO;
            pin_s2_r <= RST_ZERO;
        end
        else
        begin
            pin_s1_r <= PIN_I;
            pin_s2_r <= pin_s1_r;
        end
    end

    // With the clock stopped nothing can be sampled, so in sleep the raw
    // pins are compared against the frozen sample and set the wake flop
    // asynchronously. Glitches on enabled pins can wake the part; that
    // is the price of a clockless detector.
    wire wake_set = SLEEP_I && cn_on_r &&
                    (|(cnen_r & ~ana_in & (PIN_I ^ pin_s2_r)));

    always_ff @(posedge CLK_I or negedge RSTN_I or posedge wake_set)
    begin
        if (!RSTN_I)
        begin
            wake_r <= 1'b0;
        end
        else if (wake_set)
        begin
            wake_r <= 1'b1;
        end
        else if (!SLEEP_I)
        begin
            wake_r <= 1'b0;
        end
    end

    assign PRDATA_O  = prdata_r;
    assign PREADY_O  = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign PIN_O     = pin_o_r;
    assign PIN_OE_O  = pin_oe_r;
    assign PULLUP_O  = pu_r;
    assign PULLDN_O  = pd_r;
    assign ANALOG_O  = ansel_r;
    assign PIN_IN_O  = pin_s2_r;
    assign WAKE_O    = wake_r;
    assign IRQ_O     = cn.irq;

    // Helpers for the checks below.
    wire [NPIN-1:0] in_only = dir_r & ~ALT_EN_I;
    wire [NPIN-1:0] od_gp   = odc_r & ~ALT_EN_I;
    wire [NPIN-1:0] drv_pp  = ~dir_r & ~odc_r & ~ALT_EN_I;
    wire            full_wr = wr_ok && is_base && (PSTRB_I[1:0] == 2'b11);

    a_reset_inputs: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        $rose(RSTN_I) |-> (dir_r == RST_DIR) && (PIN_OE_O == '0))
        else $error("pins not inputs after reset");

    a_reset_analog: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        $rose(RSTN_I) |-> (ANALOG_O == RST_ANALOG))
        else $error("analog select not all ones after reset");

    a_input_no_drive: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        1'b1 |=> ((PIN_OE_O & $past(in_only)) == '0))
        else $error("input pin is driven");

    a_open_drain_high: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        1'b1 |=> ((PIN_OE_O & PIN_O & $past(od_gp)) == '0))
        else $error("open drain pin driven high");

    a_output_drives_latch: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        1'b1 |=> (((PIN_OE_O & $past(drv_pp)) == $past(drv_pp)) &&
                 (((PIN_O ^ $past(lat_r)) & $past(drv_pp)) == '0)))
        else $error("output pin does not drive its latch");

    a_alt_owns_pin: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (ALT_EN_I != '0) |=>
        ((((PIN_OE_O ^ $past(ALT_OE_I)) |
           (PIN_O ^ $past(ALT_OUT_I))) & $past(ALT_EN_I)) == '0))
        else $error("alternate function does not own its pin");

    a_latch_write: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (full_wr && (reg_idx == IDX_LAT)) |=> (lat_r == $past(wdat)))
        else $error("latch write not stored");

    a_pin_write_latch: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (full_wr && (reg_idx == IDX_PIN)) |=> (lat_r == $past(wdat)))
        else $error("pin register write missed the latch");

    a_analog_reads_zero: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        pin_read |-> ((PRDATA_O[NPIN-1:0] & $past(ana_in)) == '0))
        else $error("analog input read as nonzero");

    a_alias_set_dir: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (wr_ok && (wr_kind == GPCN_WR_SET) && (reg_idx == IDX_DIR) &&
         (PSTRB_I[1:0] == 2'b11))
        |=> (dir_r == ($past(dir_r) | $past(wdat))))
        else $error("set alias changed wrong bits");

    a_alias_clr_lat: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (wr_ok && (wr_kind == GPCN_WR_CLR) && (reg_idx == IDX_LAT) &&
         (PSTRB_I[1:0] == 2'b11))
        |=> (lat_r == ($past(lat_r) & ~$past(wdat))))
        else $error("clear alias changed wrong bits");
endmodule
`default_nettype wire

// *** testbench/gpcn_pad_model.sv ***
/*
 * Pad model: resolves every pin from the port driver, a bench driver and
 * the weak pulls. Assumes the float pattern may follow the port clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcn_pad_model
(
    // Clock.
    input  wire logic        clk_i,
    // Port side.
    input  wire logic [15:0] pin_o_i,
    input  wire logic [15:0] oe_i,
    input  wire logic [15:0] pu_i,
    input  wire logic [15:0] pd_i,
    // Bench side.
    input  wire logic [15:0] drv_en_i,
    input  wire logic [15:0] drv_val_i,
    output logic      [15:0] pin_i_o
);
    logic [15:0] float_r = 16'hA5C3;

    // A released pin with no pull wanders, so no check may lean on it.
    always_ff @(posedge clk_i)
    begin
        float_r <= ~float_r;
    end

    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (oe_i[i] && drv_en_i[i])
                pin_i_o[i] = 1'bx;
            else if (oe_i[i])
                pin_i_o[i] = pin_o_i[i];
            else if (drv_en_i[i])
                pin_i_o[i] = drv_val_i[i];
            else if (pu_i[i] != pd_i[i])
                pin_i_o[i] = pu_i[i];
            else
                pin_i_o[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

// *** testbench/gpcn_port_tb.sv ***
/*
 * Self-checking bench of the port: APB master, pad model, queue checker.
 * Assumes the port answers each APB access one cycle after setup.
 */
`timescale 1ns/1ps
`default_nettype none
module gpcn_port_tb;
    import gpcn_pkg::*;
    typedef struct { logic [32:0] v; logic [31:0] m; } gpcn_note_t;

    logic        clk     = 1'b0;
    logic        clk_run = 1'b1;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic        sleep   = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] pwdata  = 32'h0;
    logic [15:0] alt_en  = 16'h0;
    logic [15:0] alt_out = 16'h0;
    logic [15:0] alt_oe  = 16'h0;
    logic [15:0] drv_en  = 16'h0;
    logic [15:0] drv_val = 16'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wake, irq;
    logic [15:0] pin_i, pin_o, pin_oe, pull_up, pull_dn, analog, pin_in;
    logic [15:0] v, w, m, a, b;
    int          fails    = 0;
    int          n_checks = 0;
    gpcn_note_t  note;
    gpcn_note_t  notes[$];

    always #20 clk = clk_run ? ~clk : clk;

    gpcn_port u_gpcn_port
    (
        .CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE_O(pin_oe), .PULLUP_O(pull_up), .PULLDN_O(pull_dn),
        .ANALOG_O(analog), .ALT_EN_I(alt_en), .ALT_OUT_I(alt_out),
        .ALT_OE_I(alt_oe), .PIN_IN_O(pin_in), .SLEEP_I(sleep),
        .WAKE_O(wake),
        .IRQ_O(irq)
    );

    gpcn_pad_model u_gpcn_pad_model
    (
        .clk_i(clk), .pin_o_i(pin_o), .oe_i(pin_oe), .pu_i(pull_up),
        .pd_i(pull_dn), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .pin_i_o(pin_i)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string s, input logic [32:0] seen,
                         input logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
        end
    endtask

    function automatic logic [7:0] ad(input logic [3:0] i,
                                      input logic [1:0] k = 2'b00);
        return {i, k, 2'b00};
    endfunction

    // The request stays put until pready is seen high at an edge.
    task automatic xfer(input logic dw, input logic [7:0] ad_v,
                        input logic [31:0] d, input logic [32:0] e,
                        input logic [31:0] mk);
        int k;
        k = 0;
        notes.push_back('{e, mk});
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= dw;
        paddr <= ad_v;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            fails++;
            summarize;
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad_v, input logic [31:0] d);
        xfer(1'b1, ad_v, d, 33'h0, 32'h0);
    endtask

    task automatic rd(input logic [7:0] ad_v, input logic [15:0] e,
                      input logic [15:0] mk = 16'hFFFF);
        xfer(1'b0, ad_v, 32'h0, {17'h0, e & mk}, {16'h0, mk});
    endtask

    task automatic settle;
        repeat (6) @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        if (psel && pen && pready === 1'b1)
        begin
            note = notes.pop_front();
            check("apb", {pslverr, prdata & note.m}, note.v);
        end
    end

    initial
    begin
        #200000;
        fails++;
        summarize;
    end

    initial
    begin
        void'($urandom(17));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd(ad(i[3:0]), i < 2 ? 16'hFFFF : 16'h0000);
        check("analog", analog, 16'hFFFF);
        check("oe", pin_oe, 16'h0000);
        xfer(1'b0, 8'hA0, 32'h0, {1'b1, 32'h0}, 32'hFFFFFFFF);
        xfer(1'b0, 8'h01, 32'h0, {1'b1, 32'h0}, 32'hFFFFFFFF);
        xfer(1'b1, 8'hB0, 32'hFFFF, {1'b1, 32'h0}, 32'h0);
        v = 16'($urandom);
        wr(ad(IDX_ANALOG), 32'h0);
        wr(ad(IDX_LAT), v);
        rd(ad(IDX_LAT), v);
        wr(ad(IDX_DIR), 32'h0);
        settle;
        check("oe", pin_oe, 16'hFFFF);
        check("out", pin_o, v);
        rd(ad(IDX_PIN), v);
        w = 16'($urandom);
        wr(ad(IDX_PIN), w);
        rd(ad(IDX_LAT), w);
        for (int k = 1; k < 4; k++)
        begin
            m = 16'($urandom);
            wr(ad(IDX_LAT, k[1:0]), m);
            w = k == 1 ? w & ~m : k == 2 ? w | m : w ^ m;
            rd(ad(IDX_LAT), w);
            rd(ad(IDX_LAT, k[1:0]), 16'h0000);
        end
        // A base write with only the low byte lane keeps the high byte.
        pstrb <= 4'h1;
        wr(ad(IDX_LAT), ~w);
        pstrb <= 4'hF;
        w = {w[15:8], ~w[7:0]};
        rd(ad(IDX_LAT), w);
        // A peripheral that owns a pin overrides the latch and direction.
        alt_en <= 16'($urandom);
        alt_out <= 16'($urandom);
        alt_oe <= 16'($urandom);
        settle;
        check("alt_oe", pin_oe, 16'(alt_en & alt_oe | ~alt_en));
        check("alt_o", pin_o, 16'(alt_en & alt_out | ~alt_en & w));
        alt_en <= 16'h0000;
        wr(ad(IDX_ODC), 32'hFFFF);
        wr(ad(IDX_LAT), 32'h00FF);
        settle;
        check("od_oe", pin_oe, 16'hFF00);
        check("od_o", pin_o, 16'h0000);
        rd(ad(IDX_PIN), 16'h0000, 16'hFF00);
        wr(ad(IDX_ODC), 32'h0);
        wr(ad(IDX_ANALOG), 32'hFFFF);
        settle;
        check("an_oe", pin_oe, 16'hFFFF);
        check("an_o", pin_o, 16'h00FF);
        wr(ad(IDX_DIR), 32'hFFFF);
        wr(ad(IDX_ANALOG), 32'h00FF);
        settle;
        v = 16'($urandom);
        drv_en <= 16'hFFFF;
        drv_val <= v;
        settle;
        check("pin_in", pin_in, v);
        rd(ad(IDX_PIN), v & 16'hFF00);
        wr(ad(IDX_ANALOG), 32'h0);
        drv_en <= 16'h0000;
        a = 16'($urandom);
        b = 16'($urandom);
        wr(ad(IDX_PU), a);
        wr(ad(IDX_PD), b);
        settle;
        check("pu", pull_up, a);
        check("pd", pull_dn, b);
        rd(ad(IDX_PIN), a & ~b, a ^ b);
        wr(ad(IDX_PU), 32'h0);
        wr(ad(IDX_PD), 32'h0);
        drv_en <= 16'hFFFF;
        drv_val <= 16'h0000;
        wr(ad(IDX_CTRL), 32'(1) << CTRL_ON_BIT);
        wr(ad(IDX_CNEN), 32'h0003);
        settle;
        rd(ad(IDX_PIN), 16'h0000);
        wr(ad(IDX_FLAGS), 32'hFFFF);
        rd(ad(IDX_FLAGS), 16'h0000);
        drv_val <= 16'h0101;
        settle;
        check("irq", irq, 1'b1);
        rd(ad(IDX_FLAGS), 16'h0001);
        rd(ad(IDX_PIN), 16'h0101);
        rd(ad(IDX_FLAGS), 16'h0000);
        settle;
        check("irq", irq, 1'b0);
        // Sleep: the clock stands still while a pin changes.
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        clk_run = 1'b0;
        drv_val <= 16'h0103;
        #200;
        check("wake", wake, 1'b1);
        clk_run = 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        check("wake", wake, 1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check("oe", pin_oe, 16'h0000);
        check("analog", analog, 16'hFFFF);
        rstn <= 1'b1;
        rd(ad(IDX_DIR), 16'hFFFF);
        summarize;
    end
endmodule
`default_nettype wire
